// file: test/wwrs_mcu.sv
// Microcontroller model kicking the watchdog at a set spacing
`timescale 1ns/1ns
`default_nettype none

module wwrs_mcu (
    // Clock
    input wire logic clk,
    // Control
    input wire logic run,
    input wire logic [11:0] gap,
    // Kick line
    output logic kick
);
    logic [11:0] cnt_q = 12'h000;
    initial kick = 1'h0;
    // Rising edge by non-blocking assignment: the bench's falling-edge
    // changes to run are seen one half period later, with no race
    always @(posedge clk) begin
        cnt_q <= (!run || cnt_q >= gap - 12'h001) ? 12'h000 : cnt_q + 12'h001;
        kick <= run && cnt_q < 12'h003;
    end
endmodule
`default_nettype wire

// file: test/wwrs_sup_asserts.sv
// Port checks for the supervisor
`include "wwrs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module wwrs_sup_asserts #(
    parameter int HOLD_CYC = 50,
    parameter int RAMP_CYC = 20,
    parameter int CORE_CYC = 20,
    parameter int WIN_MAX = 31
) (
    // Clock
    input wire logic clk,
    input wire logic reset_n,
    // Inputs
    input wire logic supervise_in,
    input wire logic watchdog_enable,
    input wire logic regulator_enable,
    input wire logic kick_input,
    // Outputs
    input wire logic reset_out_n_o,
    input wire logic reset_out_n_oe_n,
    input wire logic watchdog_fault_n_o,
    input wire logic watchdog_fault_n_oe_n
);
    localparam int WARM = `WWRS_TIMER_WARMUP_CYC;
    localparam int UV = `WWRS_UNDERVOLT_CYC;
    localparam int LIM = CORE_CYC + WARM + (WIN_MAX + 1) * RAMP_CYC + 8;
    logic awake;
    int lo_q = 0;
    int hi_q = 0;
    int flt_q = 0;
    int gap_q = 0;
    assign awake = supervise_in | watchdog_enable | regulator_enable;
    // Run lengths in counters: such long repetitions would not unroll
    always_ff @(posedge clk) begin
        lo_q <= supervise_in ? 0 : lo_q + 1;
        hi_q <= (supervise_in && reset_n) ? hi_q + 1 : 0;
        flt_q <= watchdog_fault_n_oe_n ? 0 : flt_q + 1;
        gap_q <= (!reset_n || !watchdog_enable || !watchdog_fault_n_oe_n
            || $fell(kick_input)) ? 0 : gap_q + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_wd_idle;
        !watchdog_enable [*2] ##0 watchdog_fault_n_oe_n;
    endsequence
    sequence s_flt_end;
        $rose(watchdog_fault_n_oe_n) ##0 $past(awake);
    endsequence
    chk_od_low: assert property (!reset_out_n_o && !watchdog_fault_n_o)
        else $error("open-drain data high");
    chk_sd_reset: assert property (!awake |=> !reset_out_n_oe_n)
        else $error("reset free in shutdown");
    chk_sd_fault: assert property (!awake |=> watchdog_fault_n_oe_n)
        else $error("fault held in shutdown");
    chk_wd_off: assert property (s_wd_idle |=> watchdog_fault_n_oe_n)
        else $error("fault while disabled");
    chk_uv_late: assert property (lo_q >= UV + 5 |-> !reset_out_n_oe_n)
        else $error("reset late on undervolt");
    chk_hold_min: assert property ($rose(reset_out_n_oe_n)
        |-> hi_q >= WARM + HOLD_CYC - 2) else $error("reset hold short");
    chk_flt_len: assert property (s_flt_end
        |-> flt_q inside {[HOLD_CYC - 1:HOLD_CYC + 1]}) else $error("fault length");
    chk_win_max: assert property (gap_q < LIM)
        else $error("no fault on long gap");
endmodule

bind wwrs_supervisor wwrs_sup_asserts #(
    .HOLD_CYC(HOLD_CYC), .RAMP_CYC(RAMP_CYC),
    .CORE_CYC(CORE_CYC), .WIN_MAX(WIN_MAX)
) u_chk (.*);
`default_nettype wire

// file: test/wwrs_supervisor_tb_top.sv
// Self-checking bench for the supervisor
`include "wwrs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module wwrs_supervisor_tb_top;
    localparam int HOLD = 50;
    localparam int RAMP = 20;
    localparam int CORE = 20;
    localparam int WARM = `WWRS_TIMER_WARMUP_CYC;
    localparam int UV = `WWRS_UNDERVOLT_CYC;
    localparam int WMAX = `WWRS_WINDOW_MAX_RAMPS * RAMP;
    typedef struct {int gap; logic flt;} wwrs_row_t;
    // Kick spacing beside whether a fault pulse must show
    wwrs_row_t rows[4] = '{'{6, 1'h1}, '{60, 1'h0}, '{450, 1'h0},
        '{700, 1'h1}};
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic supervise_in = 1'h1;
    logic watchdog_enable = 1'h0;
    logic regulator_enable = 1'h0;
    logic mcu_run = 1'h0;
    logic [11:0] mcu_gap = 12'h006;
    logic kick_input;
    logic rst_oe_n;
    logic flt_oe_n;
    logic seen;
    int n_errors = 0;
    int n_compared = 0;
    int t;

    always #50 clk = ~clk;

    wwrs_supervisor #(.HOLD_CYC(HOLD), .RAMP_CYC(RAMP), .CORE_CYC(CORE)) uut (
        .clk(clk), .reset_n(reset_n), .supervise_in(supervise_in),
        .watchdog_enable(watchdog_enable), .regulator_enable(regulator_enable),
        .kick_input(kick_input), .reset_out_n_o(), .reset_out_n_oe_n(rst_oe_n),
        .watchdog_fault_n_o(), .watchdog_fault_n_oe_n(flt_oe_n));
    wwrs_mcu mcu (.clk(clk), .run(mcu_run), .gap(mcu_gap), .kick(kick_input));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Bounded so a stuck output cannot hang the run
    task automatic wait_lvl(input logic sel, input logic v, output int n);
        n = 0;
        while ((sel ? flt_oe_n : rst_oe_n) !== v && n < 4000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'h1;
        wait_lvl(1'h0, 1'h1, t);
        check(t >= CORE + WARM + HOLD && t <= CORE + WARM + HOLD + 6, 1'h1);
        foreach (rows[i]) begin
            mcu_gap = 12'(rows[i].gap);
            watchdog_enable = 1'h1;
            mcu_run = 1'h1;
            seen = 1'h0;
            repeat (WARM + 1600) begin
                @(negedge clk);
                seen = seen | !flt_oe_n;
            end
            check(seen, rows[i].flt);
            mcu_run = 1'h0;
            watchdog_enable = 1'h0;
            repeat (HOLD + 5) @(negedge clk);
            check(flt_oe_n, 1'h1);
        end
        regulator_enable = 1'h1;
        supervise_in = 1'h0;
        repeat (UV - 30) @(negedge clk);
        check(rst_oe_n, 1'h1);
        repeat (60) @(negedge clk);
        check(rst_oe_n, 1'h0);
        supervise_in = 1'h1;
        wait_lvl(1'h0, 1'h1, t);
        check(t >= WARM + HOLD - 2 && t <= WARM + HOLD + 4, 1'h1);
        watchdog_enable = 1'h1;
        wait_lvl(1'h1, 1'h0, t);
        check(t >= WARM + WMAX && t <= WARM + WMAX + RAMP + 4, 1'h1);
        watchdog_enable = 1'h0;
        regulator_enable = 1'h0;
        supervise_in = 1'h0;
        @(negedge clk);
        check({rst_oe_n, flt_oe_n}, 2'h1);
        repeat (5) @(negedge clk);
        supervise_in = 1'h1;
        wait_lvl(1'h0, 1'h1, t);
        check(t >= CORE + WARM + HOLD && t <= CORE + WARM + HOLD + 6, 1'h1);
        give_verdict;
    end

    initial begin
        #4000000;
        n_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire

// file: verilog/wwrs_consts.svh
// Timing constants and reset values for the window watchdog reset supervisor
`ifndef WWRS_CONSTS_SVH
`define WWRS_CONSTS_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define WWRS_CLK_NS 100
`define WWRS_UNDERVOLT_LATENCY_US 23
`define WWRS_TIMER_WARMUP_US 200
`define WWRS_CORE_WARMUP_US 1000
`define WWRS_KICK_MIN_PULSE_NS 300
// Cycle counts; every time rounds down to whole cycles, with no minimum
`define WWRS_UNDERVOLT_CYC ((`WWRS_UNDERVOLT_LATENCY_US * 1000) / `WWRS_CLK_NS)
`define WWRS_TIMER_WARMUP_CYC ((`WWRS_TIMER_WARMUP_US * 1000) / `WWRS_CLK_NS)
`define WWRS_CORE_WARMUP_CYC ((`WWRS_CORE_WARMUP_US * 1000) / `WWRS_CLK_NS)

// ----------------------------------------
// Window in ramp cycles
// ----------------------------------------
`define WWRS_WINDOW_MAX_RAMPS 31
`define WWRS_WINDOW_MIN_RAMPS 1

// ----------------------------------------
// Defaults of programmable periods
// ----------------------------------------
`define WWRS_HOLD_PERIOD_CYC 95000
`define WWRS_RAMP_PERIOD_CYC 5390

`endif

// file: verilog/wwrs_pkg.sv
// Types for the window watchdog reset supervisor
package wwrs_pkg;

    // ----------------------------------------
    // Supervisor phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        WWRS_SD = 2'b00,
        WWRS_CORE = 2'b01,
        WWRS_RUN = 2'b10
    } wwrs_phase_t;

    // ----------------------------------------
    // Watchdog phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        WWRS_WD_OFF = 2'b00,
        WWRS_WD_WARM = 2'b01,
        WWRS_WD_WATCH = 2'b10,
        WWRS_WD_FAULT = 2'b11
    } wwrs_wd_t;

    // ----------------------------------------
    // Reset path phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        WWRS_RS_LOW = 2'b00,
        WWRS_RS_WARM = 2'b01,
        WWRS_RS_HOLD = 2'b10,
        WWRS_RS_HIGH = 2'b11
    } wwrs_rs_t;

endpackage

// file: verilog/wwrs_supervisor.sv
// Reset supervisor and windowed watchdog core
//
// Functional notes
// - Reset output pulled low while supervised input is below threshold.
// - After supervised input recovers, reset held low one full hold period.
// - Reset asserts about 23 us after supervised input falls.
// - After power-up reset held low for the hold period.
// - Shutdown asserts reset; release one hold period after waking.
// - Watchdog runs only while enabled; when disabled, fault pin released once any fault pulse under way has ended.
// - Kick falling edges must arrive inside the window.
// - Fault pulse when kick interval is below minimum or above maximum.
// - Fault pulse lasts one hold period from the shared reset timer.
// - Fault released when the timer expires or the chip shuts down.
// - Window maximum is 31 ramp cycles.
// - Window minimum is one ramp cycle.
// - Hold or watchdog timer needs about 200 us warmup after enabling.
// - Core needs about 1 ms after leaving shutdown.
// - Shutdown when all three enables low; wake on any high.
// - Both outputs open-drain, pull low only, never drive high.
`include "wwrs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module wwrs_supervisor
    import wwrs_pkg::*;
#(
    parameter int HOLD_CYC = `WWRS_HOLD_PERIOD_CYC,
    parameter int RAMP_CYC = `WWRS_RAMP_PERIOD_CYC,
    parameter int CORE_CYC = `WWRS_CORE_WARMUP_CYC,
    parameter int WIN_MAX = `WWRS_WINDOW_MAX_RAMPS,
    parameter int WIN_MIN = `WWRS_WINDOW_MIN_RAMPS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Comparator levels
    input wire logic supervise_in,
    input wire logic watchdog_enable,
    input wire logic regulator_enable,
    input wire logic kick_input,
    // Open-drain reset, output enable low while pulling low
    output logic reset_out_n_o,
    output logic reset_out_n_oe_n,
    // Open-drain watchdog fault
    output logic watchdog_fault_n_o,
    output logic watchdog_fault_n_oe_n
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int UV_CYC = `WWRS_UNDERVOLT_CYC;
    localparam int WARM_CYC = `WWRS_TIMER_WARMUP_CYC;

    typedef struct packed {
        wwrs_phase_t phase;
        logic [31:0] core_cnt;
        wwrs_rs_t rs;
        logic [31:0] rs_cnt;
        logic [31:0] uv_cnt;
        wwrs_wd_t wd;
        logic [31:0] wd_cnt;
        logic [31:0] ramp_cnt;
        logic [7:0] win_cnt;
        logic kick_q;
        logic rst_oe_n;
        logic wdo_oe_n;
    } wwrs_state_t;

    wwrs_state_t s_q;
    wwrs_state_t s_d;

    logic awake;
    logic kick_fall;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        awake = supervise_in | watchdog_enable | regulator_enable;
        kick_fall = s_q.kick_q & ~kick_input;
        s_d.kick_q = kick_input;

        case (s_q.phase)
            WWRS_SD: begin
                if (awake) begin
                    s_d.phase = WWRS_CORE;
                    s_d.core_cnt = 32'h0;
                end
            end
            WWRS_CORE: begin
                // Supervisory timing not valid until core settles
                if (!awake) begin
                    s_d.phase = WWRS_SD;
                end else if (s_q.core_cnt >= 32'(CORE_CYC - 1)) begin
                    s_d.phase = WWRS_RUN;
                end else begin
                    s_d.core_cnt = s_q.core_cnt + 32'h1;
                end
            end
            default: begin
                if (!awake) begin
                    s_d.phase = WWRS_SD;
                end
            end
        endcase

        // Reset path; shutdown and core start keep it low
        if (s_q.phase != WWRS_RUN || s_d.phase == WWRS_SD) begin
            s_d.rs = WWRS_RS_LOW;
            s_d.rs_cnt = 32'h0;
            s_d.uv_cnt = 32'h0;
        end else begin
            case (s_q.rs)
                WWRS_RS_LOW: begin
                    if (supervise_in) begin
                        s_d.rs = WWRS_RS_WARM;
                        s_d.rs_cnt = 32'h0;
                    end
                end
                WWRS_RS_WARM: begin
                    if (!supervise_in) begin
                        s_d.rs = WWRS_RS_LOW;
                    end else if (s_q.rs_cnt >= 32'(WARM_CYC - 1)) begin
                        s_d.rs = WWRS_RS_HOLD;
                        s_d.rs_cnt = 32'h0;
                    end else begin
                        s_d.rs_cnt = s_q.rs_cnt + 32'h1;
                    end
                end
                WWRS_RS_HOLD: begin
                    if (!supervise_in) begin
                        s_d.rs = WWRS_RS_LOW;
                    end else if (s_q.rs_cnt >= 32'(HOLD_CYC - 1)) begin
                        s_d.rs = WWRS_RS_HIGH;
                        s_d.uv_cnt = 32'h0;
                    end else begin
                        s_d.rs_cnt = s_q.rs_cnt + 32'h1;
                    end
                end
                default: begin
                    // Filter short dips so glitches do not reset the host
                    if (supervise_in) begin
                        s_d.uv_cnt = 32'h0;
                    end else if (s_q.uv_cnt >= 32'(UV_CYC - 1)) begin
                        s_d.rs = WWRS_RS_LOW;
                    end else begin
                        s_d.uv_cnt = s_q.uv_cnt + 32'h1;
                    end
                end
            endcase
        end

        // Ramp oscillator, one tick per ramp cycle
        if (s_q.ramp_cnt >= 32'(RAMP_CYC - 1)) begin
            s_d.ramp_cnt = 32'h0;
        end else begin
            s_d.ramp_cnt = s_q.ramp_cnt + 32'h1;
        end

        // Watchdog
        if (s_q.phase != WWRS_RUN || s_d.phase == WWRS_SD) begin
            s_d.wd = WWRS_WD_OFF;
        end else if (!watchdog_enable && s_q.wd != WWRS_WD_FAULT) begin
            s_d.wd = WWRS_WD_OFF;
        end else begin
            case (s_q.wd)
                WWRS_WD_OFF: begin
                    s_d.wd = WWRS_WD_WARM;
                    s_d.wd_cnt = 32'h0;
                end
                WWRS_WD_WARM: begin
                    if (s_q.wd_cnt >= 32'(WARM_CYC - 1)) begin
                        s_d.wd = WWRS_WD_WATCH;
                        s_d.ramp_cnt = 32'h0;
                        s_d.win_cnt = 8'h0;
                    end else begin
                        s_d.wd_cnt = s_q.wd_cnt + 32'h1;
                    end
                end
                WWRS_WD_WATCH: begin
                    if (kick_fall && s_q.win_cnt >= 8'(WIN_MIN)) begin
                        s_d.ramp_cnt = 32'h0;
                        s_d.win_cnt = 8'h0;
                    end else if (kick_fall) begin
                        s_d.wd = WWRS_WD_FAULT;
                        s_d.wd_cnt = 32'h0;
                    end else if (s_q.ramp_cnt >= 32'(RAMP_CYC - 1)) begin
                        if (s_q.win_cnt >= 8'(WIN_MAX - 1)) begin
                            s_d.wd = WWRS_WD_FAULT;
                            s_d.wd_cnt = 32'h0;
                        end else begin
                            s_d.win_cnt = s_q.win_cnt + 8'h1;
                        end
                    end
                end
                default: begin
                    // Pulse runs to its end even if the enable drops
                    if (s_q.wd_cnt >= 32'(HOLD_CYC - 1)) begin
                        s_d.wd = WWRS_WD_WATCH;
                        s_d.ramp_cnt = 32'h0;
                        s_d.win_cnt = 8'h0;
                    end else begin
                        s_d.wd_cnt = s_q.wd_cnt + 32'h1;
                    end
                end
            endcase
        end

        // Enables kept in pin polarity so the outputs come straight from flops
        s_d.rst_oe_n = (s_d.rs == WWRS_RS_HIGH);
        s_d.wdo_oe_n = (s_d.wd != WWRS_WD_FAULT);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.wdo_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Open-drain pins
    // ----------------------------------------
    // Data held low; only the enable toggles
    assign reset_out_n_o = 1'b0;
    assign reset_out_n_oe_n = s_q.rst_oe_n;
    assign watchdog_fault_n_o = 1'b0;
    assign watchdog_fault_n_oe_n = s_q.wdo_oe_n;

endmodule

`default_nettype wire
